//--- adc_port_pkg.sv
// Constants shared by the converter output port
package adc_port_pkg;
    localparam int SAMPLE_W = 14;
    localparam int PIPE_LATENCY = 5;
    localparam int SYNC_STAGES = 3;
    localparam int BUF_DEPTH = 2;
    localparam int PTR_W = 2;
    localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
    localparam logic [SAMPLE_W-1:0] WORD_RESET = 14'h0000;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic STROBE_RESET = 1'b0;
    localparam logic OE_RESET = 1'b0;
    localparam int MSB_POS = SAMPLE_W - 1;
    // Output sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_STROBE = 3'b100
    } out_state_t;
endpackage : adc_port_pkg

//--- adc_parallel_output_port.sv
// Converter output port: encode pipeline, crossing buffer, pin driver
`timescale 1ns/100ps

// Three-stage synchroniser, output moves once stages two and three agree
module sync_agree #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire agree = (stage2 == stage3);

    // Stage one feeds stage two only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
            if (agree) begin
                o_sync <= stage3;
            end
        end
    end
endmodule : sync_agree

module adc_parallel_output_port #(
    parameter int SAMPLE_W = adc_port_pkg::SAMPLE_W,
    parameter int PIPE_LATENCY = adc_port_pkg::PIPE_LATENCY
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_encode_clock_true,
    input wire logic i_encode_clock_comp,
    input wire logic [SAMPLE_W-1:0] i_quantized_code,
    input wire logic i_above_range,
    input wire logic i_below_range,
    input wire logic i_output_format_select,
    input wire logic i_output_enable_n,
    input wire logic i_capture_ready,
    output logic [SAMPLE_W-1:0] o_sample_word,
    output logic o_sample_word_oe,
    output logic o_range_exceeded_flag,
    output logic o_data_valid_strobe,
    output logic o_overrun
);
    localparam int PW = adc_port_pkg::PTR_W;
    // Drop count width; a wider count rides out longer overrun bursts
    localparam int DW = 3;

    // ---------------- Encode clock domain ----------------
    logic [SAMPLE_W-1:0] pipe_word [PIPE_LATENCY];
    logic [PIPE_LATENCY-1:0] pipe_flag;
    logic [PIPE_LATENCY-1:0] pipe_valid;
    logic [SAMPLE_W:0] buf_mem [adc_port_pkg::BUF_DEPTH];
    logic [PW-1:0] wr_bin;
    logic [PW-1:0] wr_gray;
    logic [PW-1:0] rd_gray_wsync;
    logic [PW-1:0] rd_gray;
    logic [DW-1:0] drop_bin;
    logic [DW-1:0] drop_gray;

    // At the true rise the true input is high, so it leads only if
    // the complement is low; the clock itself is never read as data
    wire encode_high = ~i_encode_clock_comp;
    wire [DW-1:0] next_drop_bin = drop_bin + DW'(1);
    wire out_of_range = i_above_range | i_below_range;
    wire [PW-1:0] next_wr_bin = wr_bin + 2'h1;
    wire buf_full = (wr_gray == ~rd_gray_wsync);
    // Converter cannot stall; a full buffer drops the word
    wire buf_wr_ready = ~buf_full;
    wire buf_wr_valid = pipe_valid[PIPE_LATENCY-1];
    wire buf_push = buf_wr_valid & buf_wr_ready;

    // Sample taken on true rise, which is also complement fall
    always_ff @(posedge i_encode_clock_true or negedge i_nrst) begin
        if (!i_nrst) begin
            pipe_valid <= '0;
            pipe_flag <= '0;
        end else begin
            pipe_valid <= {pipe_valid[PIPE_LATENCY-2:0], encode_high};
            pipe_flag <= {pipe_flag[PIPE_LATENCY-2:0], out_of_range};
        end
    end

    // Five stages of conversion latency
    genvar gi;
    generate
        for (gi = 0; gi < PIPE_LATENCY; gi++) begin : g_pipe
            if (gi == 0) begin : g_first
                always_ff @(posedge i_encode_clock_true or negedge i_nrst) begin
                    if (!i_nrst) begin
                        pipe_word[gi] <= adc_port_pkg::WORD_RESET;
                    end else begin
                        pipe_word[gi] <= i_quantized_code;
                    end
                end
            end else begin : g_next
                always_ff @(posedge i_encode_clock_true or negedge i_nrst) begin
                    if (!i_nrst) begin
                        pipe_word[gi] <= adc_port_pkg::WORD_RESET;
                    end else begin
                        pipe_word[gi] <= pipe_word[gi-1];
                    end
                end
            end
        end
    endgenerate

    // Write side of the two-entry crossing buffer
    always_ff @(posedge i_encode_clock_true or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_bin <= adc_port_pkg::PTR_RESET;
            wr_gray <= adc_port_pkg::PTR_RESET;
        end else if (buf_push) begin
            wr_bin <= next_wr_bin;
            wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
        end
    end

    // Buffer storage, word and flag kept together
    always_ff @(posedge i_encode_clock_true) begin
        if (buf_push) begin
            buf_mem[wr_bin[0]] <= {pipe_flag[PIPE_LATENCY-1],
                                   pipe_word[PIPE_LATENCY-1]};
        end
    end

    sync_agree #(.WIDTH(PW)) u_rd_sync (
        .i_clk(i_encode_clock_true),
        .i_nrst(i_nrst),
        .i_async(rd_gray),
        .o_sync(rd_gray_wsync)
    );

    // ---------------- System clock domain, drop count on encode clock ----------------
    logic [PW-1:0] rd_bin;
    logic [PW-1:0] wr_gray_rsync;
    logic fmt_sync;
    logic oe_n_sync;
    logic ready_sync;
    logic [DW-1:0] drop_gray_rsync;
    logic [DW-1:0] seen_bin;
    logic [DW-1:0] seen_gray;
    adc_port_pkg::out_state_t state;
    adc_port_pkg::out_state_t next_state;

    sync_agree #(.WIDTH(PW)) u_wr_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(wr_gray),
        .o_sync(wr_gray_rsync)
    );

    sync_agree #(.WIDTH(3)) u_pin_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_output_format_select, i_output_enable_n,
                  i_capture_ready}),
        .o_sync({fmt_sync, oe_n_sync, ready_sync})
    );

    sync_agree #(.WIDTH(DW)) u_drop_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(drop_gray),
        .o_sync(drop_gray_rsync)
    );

    // Dropped words advance a gray count; a toggle would lose drops that
    // come closer together than the system clock can sample
    always_ff @(posedge i_encode_clock_true or negedge i_nrst) begin
        if (!i_nrst) begin
            drop_bin <= '0;
            drop_gray <= '0;
        end else if (buf_wr_valid & ~buf_wr_ready) begin
            drop_bin <= next_drop_bin;
            drop_gray <= next_drop_bin ^ (next_drop_bin >> 1);
        end
    end

    // Read side, state selection and format coding
    wire buf_rd_valid = (rd_gray != wr_gray_rsync);
    wire buf_rd_ready = (state == adc_port_pkg::ST_IDLE) & ready_sync;
    wire buf_pop = buf_rd_valid & buf_rd_ready;
    wire [PW-1:0] next_rd_bin = rd_bin + 2'h1;
    wire [SAMPLE_W:0] head = buf_mem[rd_bin[0]];
    wire msb_flip = ~fmt_sync;
    wire [SAMPLE_W-1:0] coded_word =
        {head[SAMPLE_W-1] ^ msb_flip, head[SAMPLE_W-2:0]};
    wire strobe_due = (next_state == adc_port_pkg::ST_STROBE);
    // One overrun pulse per drop still owed to the system side
    wire [DW-1:0] next_seen_bin = seen_bin + DW'(1);
    wire drop_pending = (seen_gray != drop_gray_rsync);

    always_comb begin
        next_state = state;
        unique case (state)
            adc_port_pkg::ST_IDLE: begin
                if (buf_pop) begin
                    next_state = adc_port_pkg::ST_SETUP;
                end
            end
            adc_port_pkg::ST_SETUP: begin
                next_state = adc_port_pkg::ST_STROBE;
            end
            adc_port_pkg::ST_STROBE: begin
                next_state = adc_port_pkg::ST_IDLE;
            end
            default: begin
                next_state = adc_port_pkg::ST_IDLE;
            end
        endcase
    end

    // Word set a cycle ahead of strobe rise, so it is stable at capture
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= adc_port_pkg::ST_IDLE;
            rd_bin <= adc_port_pkg::PTR_RESET;
            rd_gray <= adc_port_pkg::PTR_RESET;
            o_sample_word <= adc_port_pkg::WORD_RESET;
            o_range_exceeded_flag <= adc_port_pkg::FLAG_RESET;
            o_data_valid_strobe <= adc_port_pkg::STROBE_RESET;
        end else begin
            state <= next_state;
            o_data_valid_strobe <= strobe_due;
            if (buf_pop) begin
                rd_bin <= next_rd_bin;
                rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
                o_sample_word <= coded_word;
                o_range_exceeded_flag <= head[SAMPLE_W];
            end
        end
    end

    // Pin drive enable and overrun report
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sample_word_oe <= adc_port_pkg::OE_RESET;
            seen_bin <= '0;
            seen_gray <= '0;
            o_overrun <= 1'b0;
        end else begin
            o_sample_word_oe <= ~oe_n_sync;
            o_overrun <= drop_pending;
            if (drop_pending) begin
                seen_bin <= next_seen_bin;
                seen_gray <= next_seen_bin ^ (next_seen_bin >> 1);
            end
        end
    end
endmodule : adc_parallel_output_port

//--- adc_port_chk.sv
// Port-level assertions for the converter output port
`timescale 1ns/100ps
module adc_port_chk #(
    parameter int SAMPLE_W = 14
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_output_enable_n,
    input wire logic i_capture_ready,
    input wire logic [SAMPLE_W-1:0] o_sample_word,
    input wire logic o_sample_word_oe,
    input wire logic o_range_exceeded_flag,
    input wire logic o_data_valid_strobe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_strobe_one_cycle: assert property (
        o_data_valid_strobe |=> !o_data_valid_strobe)
        else $error("strobe too long");
    a_word_then_strobe: assert property (
        $changed(o_sample_word) |=> o_data_valid_strobe)
        else $error("word without strobe");
    a_flag_then_strobe: assert property (
        $changed(o_range_exceeded_flag) |=> o_data_valid_strobe)
        else $error("flag without strobe");
    a_word_steady: assert property (
        o_data_valid_strobe |->
            $stable(o_sample_word) && $stable(o_range_exceeded_flag))
        else $error("word moved at strobe");
    a_pins_driven: assert property (
        !i_output_enable_n [*6] |=> o_sample_word_oe)
        else $error("pins not driven");
    a_pins_released: assert property (
        i_output_enable_n [*6] |=> !o_sample_word_oe)
        else $error("pins not released");
    a_reset_quiet: assert property (
        $rose(i_nrst) |-> !o_data_valid_strobe && !o_sample_word_oe)
        else $error("busy after reset");
    a_stall_blocks: assert property (
        !i_capture_ready [*7] |-> !o_data_valid_strobe)
        else $error("strobe while stalled");
endmodule : adc_port_chk

bind adc_parallel_output_port adc_port_chk #(.SAMPLE_W(SAMPLE_W)) chk_u (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_output_enable_n(i_output_enable_n),
    .i_capture_ready(i_capture_ready),
    .o_sample_word(o_sample_word),
    .o_sample_word_oe(o_sample_word_oe),
    .o_range_exceeded_flag(o_range_exceeded_flag),
    .o_data_valid_strobe(o_data_valid_strobe)
);

//--- capture_model.sv
// Capture logic model: latches each word on the strobe rising edge
`timescale 1ns/100ps
module capture_model (
    input wire logic i_stall,
    input wire logic i_strobe,
    input wire logic [adc_port_pkg::SAMPLE_W-1:0] i_word,
    input wire logic i_flag,
    output logic o_ready,
    output logic [adc_port_pkg::SAMPLE_W-1:0] o_word,
    output logic o_flag
);
    // Ready drops while the bench asks for a stall
    assign o_ready = !i_stall;
    // Taken only at the rising edge, never while the strobe is high
    always @(posedge i_strobe) begin
        o_word <= i_word;
        o_flag <= i_flag;
    end
endmodule : capture_model

//--- tb.sv
// Self-checking bench for the converter output port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; \
    if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
    logic i_clk = 0, i_nrst = 1, encode_clock_true = 0, comp = 1, run = 0;
    logic above = 0, below = 0, fmt = 1, oen = 0, stall = 0;
    logic [13:0] code = 14'h0000, word, cap_word;
    logic oe, flag, strobe, ovr, ready, cap_flag;
    logic [14:0] expq[$], e;
    logic [15:0] rnd = 16'h000e;
    int n_fail = 0, comparisons = 0, ovr_n = 0;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    always #20 i_clk = ~i_clk;
    // Link clock stands still low between frames
    initial begin
        #3;
        forever #6 encode_clock_true = run ? ~encode_clock_true : 1'b0;
    end
    adc_parallel_output_port dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_encode_clock_true(encode_clock_true), .i_encode_clock_comp(comp),
        .i_quantized_code(code), .i_above_range(above),
        .i_below_range(below), .i_output_format_select(fmt),
        .i_output_enable_n(oen), .i_capture_ready(ready),
        .o_sample_word(word), .o_sample_word_oe(oe),
        .o_range_exceeded_flag(flag), .o_data_valid_strobe(strobe),
        .o_overrun(ovr));
    capture_model cap_u (.i_stall(stall), .i_strobe(strobe), .i_word(word),
        .i_flag(flag), .o_ready(ready), .o_word(cap_word), .o_flag(cap_flag));
    // Oldest note against each captured word
    always @(posedge strobe) begin
        #1;
        e = expq.size() > 0 ? expq.pop_front() : 15'h7fff;
        `CHK("word", e[13:0], cap_word)
        `CHK("flag", e[14], cap_flag)
    end
    // Counted off the falling edge, half a cycle after the rising launch edge, where the pulse has settled
    always @(negedge i_clk) if (ovr === 1'b1) ovr_n++;
    // Comp low only on edges that should sample; high edges are bubbles
    task automatic send(input logic [13:0] c, input logic a, input logic b,
                        input bit keep, input int gap);
        @(negedge encode_clock_true);
        code = c;
        above = a;
        below = b;
        comp = 1'b0;
        if (keep) expq.push_back({a | b, c ^ {~fmt, 13'h0000}});
        @(negedge encode_clock_true);
        comp = 1'b1;
        repeat (gap) @(negedge encode_clock_true);
    endtask : send
    // Eight more edges push the pipeline out, then the link clock stops
    task automatic tail();
        repeat (8) @(negedge encode_clock_true);
        run = 1'b0;
    endtask : tail
    task automatic drain();
        for (int k = 0; k < 400 && expq.size() > 0; k++) @(negedge i_clk);
        `CHK("pending", 0, expq.size())
    endtask : drain
    task automatic summarize();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        // A real falling edge, so both domains see the reset
        #1;
        i_nrst = 1'b0;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        i_nrst = 1'b1;
        // Both codings, extremes first, then random codes
        for (int f = 0; f < 2; f++) begin
            fmt = f[0];
            repeat (8) @(negedge i_clk);
            run = 1'b1;
            send(14'h0000, 1'b0, 1'b1, 1, 11);
            send(14'h3fff, 1'b1, 1'b0, 1, 11);
            for (int i = 0; i < 4; i++) begin
                rnd = lfsr(rnd);
                send(rnd[13:0], rnd[14], 1'b0, 1, 11);
            end
            tail();
            drain();
        end
        // Four edges after a sample leave it inside; the fifth brings it out
        repeat (8) @(negedge i_clk);
        run = 1'b1;
        rnd = lfsr(rnd);
        send(rnd[13:0], 1'b0, rnd[15], 1, 0);
        repeat (4) @(negedge encode_clock_true);
        run = 1'b0;
        repeat (20) @(negedge i_clk);
        `CHK("early", 1, expq.size())
        run = 1'b1;
        @(negedge encode_clock_true);
        run = 1'b0;
        drain();
        oen = 1'b1;
        repeat (8) @(negedge i_clk);
        `CHK("oe", 1'b0, oe)
        oen = 1'b0;
        repeat (8) @(negedge i_clk);
        `CHK("oe", 1'b1, oe)
        // Stalled capture: two words fill the buffer, two are dropped
        stall = 1'b1;
        ovr_n = 0;
        repeat (8) @(negedge i_clk);
        run = 1'b1;
        for (int i = 0; i < 4; i++) begin
            send(14'h1000 | 14'(i), 1'b0, 1'b0, i < 2, 0);
        end
        tail();
        repeat (20) @(negedge i_clk);
        `CHK("overruns", 2, ovr_n)
        stall = 1'b0;
        drain();
        summarize();
    end
endmodule : tb
